// file: design/tpsr_top.sv
/*
 * Receiver back end: counting tone-pair decoder, early-valid output,
 * steering/guard logic, delayed steering flag, digit latch and the
 * AXI4-Lite register slave with sticky events and interrupt.
 * Assumes limited group tone inputs and the steering comparator level
 * arrive asynchronous to aclk and pass two synchronizer stages; an external RC network sits on the steering pin.
 */
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "tpsr_defs.svh"

module tpsr_top
	import tpsr_pkg::*;
#(
	parameter int MATCH_PERIODS = `TPSR_MATCH_PERIODS,
	parameter int SETTLE_CYC = `TPSR_SETTLE_CYC
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset
	input wire logic low_tone_in, // limited low-group tone
	input wire logic high_tone_in, // limited high-group tone
	output logic early_pair_valid, // valid pair present
	input wire logic steer_threshold_in, // steering pin above threshold
	output logic guard_time_out, // guard drive level
	output logic guard_oe_n, // guard drive enable
	output logic irq_or_progress_out, // open-drain request level
	output logic irq_or_progress_oe_n, // open-drain request enable
	output logic irq, // masked event interrupt
	input wire logic [`TPSR_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [`TPSR_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [31:0] tone_hz(input logic grp, input logic [1:0] idx);
		logic [31:0] hz;
		hz = 32'(`TPSR_LOW_HZ0);
		case ({grp, idx})
			3'h0: hz = 32'(`TPSR_LOW_HZ0);
			3'h1: hz = 32'(`TPSR_LOW_HZ1);
			3'h2: hz = 32'(`TPSR_LOW_HZ2);
			3'h3: hz = 32'(`TPSR_LOW_HZ3);
			3'h4: hz = 32'(`TPSR_HIGH_HZ0);
			3'h5: hz = 32'(`TPSR_HIGH_HZ1);
			3'h6: hz = 32'(`TPSR_HIGH_HZ2);
			3'h7: hz = 32'(`TPSR_HIGH_HZ3);
			default: hz = 32'(`TPSR_LOW_HZ0);
		endcase
		return hz;
	endfunction : tone_hz

	// Period in clocks measured between rising edges; returns {hit, bin}
	function automatic logic [2:0] classify(input logic grp,
		input logic [`TPSR_CNT_W-1:0] period);
		logic [2:0] res;
		logic [31:0] nom;
		logic [31:0] tol;
		res = 3'h0;
		nom = 32'h0;
		tol = 32'h0;
		for (int i = 0; i < 4; i++) begin
			nom = 32'(`TPSR_CLK_HZ) / tone_hz(grp, 2'(i));
			tol = (nom * 32'(`TPSR_TOL_PCT)) / 32'd100;
			if ({14'h0, period} >= nom - tol && {14'h0, period} <= nom + tol) begin
				res = {1'b1, 2'(i)};
			end
		end
		return res;
	endfunction : classify

	// One tone channel: period counter plus consecutive-match averaging
	function automatic tpsr_chan_type chan_step(input tpsr_chan_type c,
		input logic grp, input logic pin);
		tpsr_chan_type n;
		logic [2:0] hit;
		logic edge_seen;
		n = c;
		hit = classify(grp, c.cnt);
		n.sync = {c.sync[0], pin};
		n.prev = c.sync[1];
		edge_seen = c.sync[1] && !c.prev;
		if (edge_seen) begin
			n.cnt = `TPSR_CNT_W'(1);
			if (hit[2] && hit[1:0] == c.bin) begin
				if (c.match < `TPSR_MATCH_W'(MATCH_PERIODS)) begin
					n.match = c.match + `TPSR_MATCH_W'(1);
				end
			end else if (hit[2]) begin
				n.bin = hit[1:0];
				n.match = `TPSR_MATCH_W'(1);
			end else begin
				n.match = '0;
			end
		end else if (&c.cnt) begin
			// Tone vanished: no edge within the counter range
			n.match = '0;
		end else begin
			n.cnt = c.cnt + `TPSR_CNT_W'(1);
			if (c.match != '0 && classify(grp, c.cnt + `TPSR_CNT_W'(1)) == 3'h0 &&
				c.cnt > `TPSR_CNT_W'(`TPSR_CLK_HZ / `TPSR_LOW_HZ0)) begin
				n.match = '0;
			end
		end
		return n;
	endfunction : chan_step

	function automatic logic [3:0] digit_code(input logic [1:0] row, input logic [1:0] col);
		logic [63:0] table_bits;
		table_bits = `TPSR_DIGIT_TABLE;
		return table_bits[{row, col, 2'h0} +: 4];
	endfunction : digit_code

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : wmerge

	// ----------------------------------------
	// State
	// ----------------------------------------
	tpsr_state_type state;
	tpsr_state_type next_state;
	logic pair_now;
	logic steer_s;
	logic early_s;
	logic registered;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_write;
	logic [`TPSR_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [`TPSR_EVT_W-1:0] evt_set;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic rd_clear;

	assign pair_now = state.low.match >= `TPSR_MATCH_W'(MATCH_PERIODS) &&
		state.high.match >= `TPSR_MATCH_W'(MATCH_PERIODS);
	assign steer_s = state.steer_sync[1];
	assign early_s = state.early_sync[1];
	assign registered = state.steer != tpsr_idle;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// Write may complete with address and data arriving in either order
	assign wr_addr = state.aw_held ? state.aw_addr : s_axi_awaddr;
	assign wr_data = state.w_held ? state.w_data : s_axi_wdata;
	assign wr_strb = state.w_held ? state.w_strb : s_axi_wstrb;
	assign do_write = (state.aw_held || aw_take) && (state.w_held || w_take) &&
		!state.bvalid;

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0;
		rd_resp = `TPSR_RESP_OKAY;
		rd_clear = 1'b0;
		case (s_axi_araddr)
			`TPSR_REG_RX_DATA: rd_word[3:0] = state.rx_data;
			`TPSR_REG_TX_DATA: rd_word[3:0] = state.tx_data;
			`TPSR_REG_CTRL_A: rd_word[7:0] = state.ctrl_a;
			`TPSR_REG_CTRL_B: rd_word[7:0] = state.ctrl_b;
			`TPSR_REG_STATUS: begin
				rd_word[`TPSR_STATUS_DSTEER] = state.dsteer;
				rd_word[`TPSR_STATUS_EARLY] = state.early;
				rd_word[`TPSR_STATUS_STEER] = steer_s;
			end
			`TPSR_REG_EVENT: begin
				rd_word[`TPSR_EVT_W-1:0] = state.event_bits;
				rd_clear = 1'b1;
			end
			`TPSR_REG_MASK: rd_word[`TPSR_EVT_W-1:0] = state.mask;
			default: rd_resp = `TPSR_RESP_SLVERR;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		evt_set = '0;

		// Tone decoder
		next_state.low = chan_step(state.low, 1'b0, low_tone_in);
		next_state.high = chan_step(state.high, 1'b1, high_tone_in);
		next_state.early = pair_now;
		next_state.early_sync = {state.early_sync[0], state.early};
		next_state.steer_sync = {state.steer_sync[0], steer_threshold_in};
		if (state.early && !pair_now) begin
			evt_set[`TPSR_EVT_LOST] = 1'b1;
		end

		// Steering: the RC network times both guard periods
		case (state.steer)
			tpsr_idle: begin
				next_state.dsteer = 1'b0;
				if (steer_s && early_s) begin
					next_state.pending = digit_code(state.low.bin, state.high.bin);
					next_state.settle = '0;
					next_state.steer = tpsr_settle;
				end
			end
			tpsr_settle: begin
				if (!steer_s) begin
					next_state.steer = tpsr_idle;
				end else if (state.settle >= `TPSR_SETTLE_W'(SETTLE_CYC - 1)) begin
					next_state.dsteer = 1'b1;
					next_state.rx_data = state.pending;
					next_state.steer = tpsr_held;
					evt_set[`TPSR_EVT_DIGIT] = 1'b1;
				end else begin
					next_state.settle = state.settle + `TPSR_SETTLE_W'(1);
				end
			end
			tpsr_held: begin
				// Short drop-outs never pull the RC node below threshold
				if (!steer_s) begin
					next_state.dsteer = 1'b0;
					next_state.steer = tpsr_idle;
				end
			end
			default: begin
				next_state.steer = tpsr_idle;
				next_state.dsteer = 1'b0;
			end
		endcase

		// Bus write side
		if (aw_take && !do_write) begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = s_axi_awaddr;
		end
		if (w_take && !do_write) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = `TPSR_RESP_OKAY;
			case (wr_addr)
				`TPSR_REG_TX_DATA:
					next_state.tx_data = 4'(wmerge({28'h0, state.tx_data}, wr_data, wr_strb));
				`TPSR_REG_CTRL_A:
					next_state.ctrl_a = 8'(wmerge({24'h0, state.ctrl_a}, wr_data, wr_strb));
				`TPSR_REG_CTRL_B:
					next_state.ctrl_b = 8'(wmerge({24'h0, state.ctrl_b}, wr_data, wr_strb));
				`TPSR_REG_MASK:
					next_state.mask = `TPSR_EVT_W'(wmerge({30'h0, state.mask}, wr_data,
						wr_strb));
				`TPSR_REG_RX_DATA, `TPSR_REG_STATUS, `TPSR_REG_EVENT: begin
				end
				default: next_state.bresp = `TPSR_RESP_SLVERR;
			endcase
		end else if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end

		// Bus read side
		if (ar_take) begin
			next_state.rvalid = 1'b1;
			next_state.rdata = rd_word;
			next_state.rresp = rd_resp;
		end else if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end

		// Sticky events: a new event beats the clear of the same read
		if (ar_take && rd_clear) begin
			next_state.event_bits = evt_set;
		end else begin
			next_state.event_bits = state.event_bits | evt_set;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= '0;
			state.steer <= tpsr_idle;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign early_pair_valid = state.early;
	// Guard holds the RC node while a digit is registered
	assign guard_time_out = early_s;
	assign guard_oe_n = !registered;
	// Open drain: level fixed low, only the enable moves
	assign irq_or_progress_out = 1'b0;
	assign irq_or_progress_oe_n = !(state.ctrl_a[`TPSR_CTRL_A_IRQ_MODE] && state.dsteer);
	assign irq = |(state.event_bits & state.mask);
	assign s_axi_awready = !state.aw_held && !state.bvalid;
	assign s_axi_wready = !state.w_held && !state.bvalid;
	assign s_axi_bvalid = state.bvalid;
	assign s_axi_bresp = state.bresp;
	assign s_axi_arready = !state.rvalid;
	assign s_axi_rvalid = state.rvalid;
	assign s_axi_rdata = state.rdata;
	assign s_axi_rresp = state.rresp;

endmodule : tpsr_top

`default_nettype wire

// file: shared/tpsr_defs.svh
/*
 * Constants of the tone pair steering register: timing, tone frequencies,
 * register offsets and field positions.
 * Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
// Summary of operation
// - Early-valid goes high once both group tones are recognised together.
// - Early-valid drops at once when the valid pair condition is lost.
// - Steering above threshold registers the current pair and updates the latch.
// - Steering below threshold frees the receiver to accept a new pair.
// - Guard output follows early-valid and steering level, resetting the RC network.
// - After registration guard drives high while early-valid stays high.
// - Pair registers only after early-valid held for the RC validation period.
// - Delayed steering flag rises after a short latch settling delay.
// - Delayed steering flag is readable as a status bit.
// - In interrupt mode the open-drain request pulls low while the flag is set.
// - Output latch updates only on the rising edge of delayed steering.
// - Reading the receive data register returns the latched four-bit code.
// - Drop-outs shorter than the absent guard time do not end a digit.
// - Tone frequencies found by counting limited inputs, checked against standard set.
// - Host sees one status, two control and two data registers; the code also has an event and a mask register.
// - Digits 1-9 binary, 0 is ten, star eleven, hash twelve, A-C 13-15, D zero.
`ifndef TPSR_DEFS_SVH
`define TPSR_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TPSR_CLK_HZ 50000000
`define TPSR_CLK_PERIOD_NS 20
`define TPSR_SETTLE_NS 100
`define TPSR_SETTLE_CYC ((`TPSR_SETTLE_NS + `TPSR_CLK_PERIOD_NS - 1) / `TPSR_CLK_PERIOD_NS)
`define TPSR_CNT_W 18
`define TPSR_SETTLE_W 8

// ----------------------------------------
// Tone detection
// ----------------------------------------
`define TPSR_LOW_HZ0 697
`define TPSR_LOW_HZ1 770
`define TPSR_LOW_HZ2 852
`define TPSR_LOW_HZ3 941
`define TPSR_HIGH_HZ0 1209
`define TPSR_HIGH_HZ1 1336
`define TPSR_HIGH_HZ2 1477
`define TPSR_HIGH_HZ3 1633
`define TPSR_TOL_PCT 3
`define TPSR_MATCH_PERIODS 4
`define TPSR_MATCH_W 3
// Digit code indexed by {row, column}
`define TPSR_DIGIT_TABLE 64'h0cab_f987_e654_d321

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define TPSR_ADDR_W 8
`define TPSR_REG_RX_DATA 8'h00
`define TPSR_REG_TX_DATA 8'h04
`define TPSR_REG_CTRL_A 8'h08
`define TPSR_REG_CTRL_B 8'h0c
`define TPSR_REG_STATUS 8'h10
`define TPSR_REG_EVENT 8'h14
`define TPSR_REG_MASK 8'h18
`define TPSR_CTRL_A_IRQ_MODE 0
`define TPSR_STATUS_DSTEER 0
`define TPSR_STATUS_EARLY 1
`define TPSR_STATUS_STEER 2
`define TPSR_EVT_DIGIT 0
`define TPSR_EVT_LOST 1
`define TPSR_EVT_W 2
`define TPSR_RESP_OKAY 2'h0
`define TPSR_RESP_SLVERR 2'h2

`endif

// file: shared/tpsr_pkg.sv
/*
 * Types of the tone pair steering register: steering states and the
 * packed state record of the top module.
 * Assumes tpsr_defs.svh is on the include path.
 */
`include "tpsr_defs.svh"
`default_nettype none

package tpsr_pkg;

	typedef enum logic [1:0] {
		tpsr_idle,
		tpsr_settle,
		tpsr_held
	} tpsr_steer_type;

	typedef struct packed {
		logic [`TPSR_CNT_W-1:0] cnt;
		logic [1:0] sync;
		logic prev;
		logic [1:0] bin;
		logic [`TPSR_MATCH_W-1:0] match;
	} tpsr_chan_type;

	typedef struct packed {
		tpsr_chan_type low;
		tpsr_chan_type high;
		logic early;
		logic [1:0] early_sync;
		logic [1:0] steer_sync;
		tpsr_steer_type steer;
		logic [`TPSR_SETTLE_W-1:0] settle;
		logic [3:0] pending;
		logic [3:0] rx_data;
		logic dsteer;
		logic [3:0] tx_data;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [`TPSR_EVT_W-1:0] event_bits;
		logic [`TPSR_EVT_W-1:0] mask;
		logic aw_held;
		logic [`TPSR_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tpsr_state_type;

endpackage : tpsr_pkg

`default_nettype wire

// file: verification/tb_tpsr_top.sv
/* Bench of the steering register: register map, one digit and its loss.
 * Assumes the RC model on the steering pin and a pull-up on the request pin. */
`timescale 1ns/1ps
`default_nettype none
`include "tpsr_defs.svh"
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module tb_tpsr_top
	import tpsr_pkg::*;
;
	localparam int LO_HALF = 26567;
	localparam int HI_HALF = 16926;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic low_tone_in = 1'b0, high_tone_in = 1'b0, tone_on = 1'b0, glitch = 1'b0, slow_rd = 1'b0;
	logic early_pair_valid, steer_threshold_in, guard_time_out, guard_oe_n, irq, irq_pin;
	logic irq_or_progress_out, irq_or_progress_oe_n, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, s_axi_wdata = 32'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	// Both tones rise on the first enabled cycle to keep acquisition short
	int errors = 0, checks = 0, lo_cnt = LO_HALF - 1, hi_cnt = HI_HALF - 1;
	logic [7:0] wadr [6] = '{8'h04, 8'h08, 8'h0c, 8'h18, 8'h00, 8'h10};
	logic [31:0] wexp [6] = '{32'h7, 32'h37, 32'h37, 32'h3, 32'h0, 32'h0};
	tpsr_top #(.MATCH_PERIODS(1), .SETTLE_CYC(5)) u_tpsr_top (.aclk, .aresetn, .low_tone_in,
		.high_tone_in, .early_pair_valid, .steer_threshold_in, .guard_time_out, .guard_oe_n,
		.irq_or_progress_out, .irq_or_progress_oe_n, .irq, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	tpsr_steer_rc u_tpsr_steer_rc (.aclk, .aresetn, .early_pair_valid, .guard_time_out,
		.guard_oe_n, .steer_threshold_in);
	assign irq_pin = irq_or_progress_oe_n ? 1'b1 : irq_or_progress_out;
	always #10 aclk = ~aclk;
	// ----------------------------------------
	// Tone source: digit hash, then a burst of short periods
	// ----------------------------------------
	always @(posedge aclk) begin
		if (glitch) begin
			low_tone_in <= ~low_tone_in;
		end else if (tone_on) begin
			lo_cnt <= (lo_cnt == LO_HALF - 1) ? 0 : lo_cnt + 1;
			hi_cnt <= (hi_cnt == HI_HALF - 1) ? 0 : hi_cnt + 1;
			if (lo_cnt == LO_HALF - 1) low_tone_in <= ~low_tone_in;
			if (hi_cnt == HI_HALF - 1) high_tone_in <= ~high_tone_in;
		end
	end
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask : reg_wr
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow_rd;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			// Late ready leaves the answer waiting for one cycle
			if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
		end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK("rdata", e, s_axi_rdata)
		`CHK("rresp", er, s_axi_rresp)
	endtask : expect_rd
	task automatic await(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge aclk);
			n++;
		end
	endtask : await
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("guard_oe_n", 1'b1, guard_oe_n)
		`CHK("irq_pin", 1'b1, irq_pin)
		for (int a = 0; a < 8'h1c; a += 4) expect_rd(8'(a), 32'h0, `TPSR_RESP_OKAY);
		expect_rd(8'h1c, 32'h0, `TPSR_RESP_SLVERR);
		reg_wr(8'h40, 32'h1);
		`CHK("bresp", `TPSR_RESP_SLVERR, rsp)
		for (int i = 0; i < 6; i++) begin
			reg_wr(wadr[i], 32'hffff_ff37);
			`CHK("bresp", `TPSR_RESP_OKAY, rsp)
			expect_rd(wadr[i], wexp[i], `TPSR_RESP_OKAY);
		end
		// Strobes without byte 0 leave the low byte alone
		s_axi_wstrb <= 4'he;
		reg_wr(`TPSR_REG_CTRL_B, 32'h0);
		expect_rd(`TPSR_REG_CTRL_B, 32'h37, `TPSR_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		tone_on <= 1'b1;
		await(early_pair_valid, 1'b1, 60000);
		`CHK("early", 1'b1, early_pair_valid)
		await(irq_or_progress_oe_n, 1'b0, 500);
		`CHK("irq_pin", 1'b0, irq_pin)
		`CHK("guard", 2'b10, {guard_time_out, guard_oe_n})
		`CHK("irq", 1'b1, irq)
		expect_rd(`TPSR_REG_RX_DATA, 32'hc, `TPSR_RESP_OKAY);
		slow_rd = 1'b1;
		expect_rd(`TPSR_REG_STATUS, 32'h7, `TPSR_RESP_OKAY);
		slow_rd = 1'b0;
		expect_rd(`TPSR_REG_EVENT, 32'h1, `TPSR_RESP_OKAY);
		expect_rd(`TPSR_REG_EVENT, 32'h0, `TPSR_RESP_OKAY);
		`CHK("irq", 1'b0, irq)
		reg_wr(`TPSR_REG_CTRL_A, 32'h36);
		`CHK("irq_pin", 1'b1, irq_pin)
		reg_wr(`TPSR_REG_CTRL_A, 32'h37);
		`CHK("irq_pin", 1'b0, irq_pin)
		glitch <= 1'b1;
		repeat (6) @(posedge aclk);
		glitch <= 1'b0;
		tone_on <= 1'b0;
		await(early_pair_valid, 1'b0, 20);
		`CHK("early", 1'b0, early_pair_valid)
		repeat (10) @(posedge aclk);
		`CHK("irq_pin", 1'b0, irq_pin)
		await(irq_or_progress_oe_n, 1'b1, 200);
		`CHK("irq_pin", 1'b1, irq_pin)
		`CHK("guard_oe_n", 1'b1, guard_oe_n)
		`CHK("irq", 1'b1, irq)
		expect_rd(`TPSR_REG_STATUS, 32'h0, `TPSR_RESP_OKAY);
		expect_rd(`TPSR_REG_EVENT, 32'h2, `TPSR_RESP_OKAY);
		expect_rd(`TPSR_REG_RX_DATA, 32'hc, `TPSR_RESP_OKAY);
		print_verdict();
	end
	// Digit acquisition alone takes some 53k cycles
	initial begin
		repeat (80000) @(posedge aclk);
		errors++;
		print_verdict();
	end
endmodule : tb_tpsr_top
`default_nettype wire

// file: verification/tpsr_steer_rc.sv
/* Behavioural RC steering network on the steering pin.
 * Assumes one clock; counts stand in for the capacitor charge. */
`timescale 1ns/1ps
`default_nettype none
module tpsr_steer_rc #(
	parameter int GTP = 30,
	parameter int GTA = 40
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic early_pair_valid, // charges the node
	input wire logic guard_time_out, // guard level
	input wire logic guard_oe_n, // guard enable
	output logic steer_threshold_in // node above threshold
);
	logic drive;
	int cnt;
	// Guard takes the node over while it drives
	assign drive = guard_oe_n ? early_pair_valid : guard_time_out;
	// Level equal to the output restarts the count, so short drop-outs are absorbed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 0;
			steer_threshold_in <= 1'b0;
		end else if (drive == !steer_threshold_in) begin
			cnt <= cnt + 1;
			if (cnt == (steer_threshold_in ? GTA : GTP) - 1) begin
				steer_threshold_in <= drive;
				cnt <= 0;
			end
		end else begin
			cnt <= 0;
		end
	end
endmodule : tpsr_steer_rc
`default_nettype wire

// file: verification/tpsr_top_props.sv
/* Port checker of the tone pair steering register.
 * Assumes it is bound onto tpsr_top and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module tpsr_top_props
	import tpsr_pkg::*;
#(
	parameter int MATCH_PERIODS = 4,
	parameter int SETTLE_CYC = 5
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic early_pair_valid, // early valid
	input wire logic steer_threshold_in, // steering level
	input wire logic guard_time_out, // guard level
	input wire logic guard_oe_n, // guard enable
	input wire logic irq_or_progress_out, // request level
	input wire logic irq_or_progress_oe_n, // request enable
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [31:0] s_axi_rdata // read data
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Steering
	// ----------------------------------------
	AST_GUARD_FOLLOW: assert property (!guard_oe_n |-> guard_time_out == $past(early_pair_valid, 2))
		else $error("guard level not early valid delayed");
	// Six cycles covers the sync stages and the state flop
	AST_REG_TAKE: assert property ((steer_threshold_in && early_pair_valid)[*6] |-> !guard_oe_n)
		else $error("steering high but pair not registered");
	AST_FREE: assert property ((!steer_threshold_in)[*6] |-> guard_oe_n)
		else $error("steering low but digit still held");
	AST_FLAG_DELAY: assert property ($fell(irq_or_progress_oe_n) |-> $past(guard_oe_n, 3) == 1'b0)
		else $error("flag rose without settling delay");
	AST_FLAG_HELD: assert property (!irq_or_progress_oe_n |-> !guard_oe_n)
		else $error("request pulled outside a registered digit");
	AST_OPEN_DRAIN: assert property (irq_or_progress_out == 1'b0)
		else $error("request pin driven high");
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	AST_BRESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write response late");
	AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	COV_EARLY: cover property ($rose(early_pair_valid));
	COV_FLAG: cover property ($fell(irq_or_progress_oe_n));
	COV_WRITE: cover property ($rose(s_axi_bvalid));
endmodule : tpsr_top_props
bind tpsr_top tpsr_top_props #(.MATCH_PERIODS(MATCH_PERIODS), .SETTLE_CYC(SETTLE_CYC)) u_props (
	.aclk, .aresetn, .early_pair_valid, .steer_threshold_in, .guard_time_out, .guard_oe_n,
	.irq_or_progress_out, .irq_or_progress_oe_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata);
`default_nettype wire
